/* phy_pin_pkg.sv */
// Purpose: shared constants and types of the strap, LED and reset block
// Assumes: one 200 MHz clock, register bus of AXI4-Lite with 32-bit data
// Notes: register byte address is the register index times four
package phy_pin_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int RST_TIME_US = 1000;
    // more than the time, so one cycle beyond the exact count
    localparam logic [23:0] RST_CYCLES = 24'(RST_TIME_US * CLK_MHZ + 1);
    localparam int ACT_BLINK_HZ = 10;
    localparam int COL_BLINK_HZ = 20;
    localparam logic [23:0] ACT_HALF_CYCLES = 24'(CLK_HZ / (2 * ACT_BLINK_HZ));
    localparam logic [23:0] COL_HALF_CYCLES = 24'(CLK_HZ / (2 * COL_BLINK_HZ));

    // ************************************************************
    // register map
    // ************************************************************
    localparam int CTRL_IDX = 0;
    localparam int LCFG_IDX = 19;
    localparam int STRAP_IDX = 20;
    localparam logic [7:0] ADDR_CTRL = 8'(CTRL_IDX * 4);
    localparam logic [7:0] ADDR_LCFG = 8'(LCFG_IDX * 4);
    localparam logic [7:0] ADDR_STRAP = 8'(STRAP_IDX * 4);
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] LCFG_RST = 16'h0000;
    localparam int CTRL_LOOPBACK_BIT = 14;
    localparam int CTRL_AUTONEG_BIT = 12;
    localparam int CTRL_PWRDN_BIT = 11;
    localparam int LCFG_MLT3_BYP_BIT = 1;
    localparam int STRAP_LSB = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // LED pin order, bit 0 is the 100M pin
    // ************************************************************
    localparam int LED_NUM = 5;
    localparam int LED_HUNDRED = 0;
    localparam int LED_COLL = 1;
    localparam int LED_LINK = 2;
    localparam int LED_ACT = 3;
    localparam int LED_TEN = 4;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_RUN = 3'b100
    } phase_t;

endpackage : phy_pin_pkg

/* pin_sync2.sv */
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : pin_sync2

/* led_blink.sv */
// Purpose: square-wave blink source for one LED
// Assumes: half period given in clock cycles
// Notes: output turns on one cycle after enable rises
`timescale 1ns/10ps
module led_blink #(
    parameter logic [23:0] HALF_CYCLES = 24'h000010
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic enable_i,
    output logic blink_o
);
    logic [23:0] cnt_q;
    wire terminal = (cnt_q == HALF_CYCLES - 24'h000001);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !enable_i) begin
            // preset to terminal so the first flash starts at once
            cnt_q <= HALF_CYCLES - 24'h000001;
            blink_o <= 1'b0;
        end else if (terminal) begin
            cnt_q <= 24'h000000; // RL18
            blink_o <= !blink_o;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
        end
    end

    blink_toggle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL18
        enable_i && terminal |=> blink_o != $past(blink_o))
        else $error("blink did not toggle at half period");
    blink_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL18
        enable_i && !terminal ##1 enable_i |-> $stable(blink_o))
        else $error("blink changed inside half period");
    blink_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL18
        !enable_i |=> !blink_o)
        else $error("blink on while disabled");
endmodule : led_blink

/* phy_pin_ctrl.sv */
// Purpose: strap sampling, LED drive and reset sequencing of the transceiver pins
// Assumes: link status inputs come from logic on clk_i; strap and reset pins do not
// Notes: registers over AXI4-Lite, reachable once reset_done_flag_o is high
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// How it works
// RL1 - strap low makes its LED active high
// RL2 - strap high makes its LED active low
// RL3 - five strap levels land in status bits 7..3
// RL4 - ten LED on while 10Mb/s detected
// RL5 - activity LED blinks 10 Hz on traffic
// RL6 - link LED on while link is good
// RL7 - duplex LED on in full duplex
// RL8 - duplex LED blinks 20 Hz on half-duplex collision
// RL9 - hundred LED on while 100Mb/s detected
// RL10 - with autoneg, two straps pick advertisement
// RL11 - no autoneg: strap A sets MLT3 bypass bit
// RL12 - no autoneg: strap B sets loopback bit
// RL13 - board holds reset pin low 1 ms
// RL14 - power-up reset lasts more than 1 ms
// RL15 - reset done flag high only after reset
// RL16 - power-down floats all LED pins
// RL17 - software waits for reset done first
// RL18 - blink rates counted from the clock
module phy_pin_ctrl
    import phy_pin_pkg::*;
#(
    parameter logic [23:0] RST_CYC = phy_pin_pkg::RST_CYCLES,
    parameter logic [23:0] ACT_HALF = phy_pin_pkg::ACT_HALF_CYCLES,
    parameter logic [23:0] COL_HALF = phy_pin_pkg::COL_HALF_CYCLES
) (
    // clock and power-on reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // board pins
    input wire logic ext_reset_n_i,
    input wire logic power_down_pin_i,
    input wire logic autoneg_strap_i,
    input wire logic config_strap_a_i,
    input wire logic config_strap_b_i,
    output logic reset_done_flag_o,
    // LED and strap pins, bit order per package
    input wire logic [phy_pin_pkg::LED_NUM-1:0] led_i,
    output logic [phy_pin_pkg::LED_NUM-1:0] led_o,
    output logic [phy_pin_pkg::LED_NUM-1:0] led_oe_o,
    // link status from the transceiver core
    input wire logic speed_ten_det_i,
    input wire logic speed_hundred_det_i,
    input wire logic link_good_i,
    input wire logic activity_i,
    input wire logic full_duplex_i,
    input wire logic collision_i,
    // configuration to the transceiver core
    output logic autoneg_en_o,
    output logic [1:0] advertise_sel_o,
    output logic mlt3_bypass_o,
    output logic loopback_o,
    output logic power_down_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import phy_pin_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [LED_NUM-1:0] strap_sync;
    logic [4:0] pins_sync;

    pin_sync2 #(.W(LED_NUM)) u_strap_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(led_i),
        .sync_o(strap_sync)
    );

    pin_sync2 #(.W(5)) u_pin_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({ext_reset_n_i, power_down_pin_i, autoneg_strap_i,
                  config_strap_b_i, config_strap_a_i}),
        .sync_o(pins_sync)
    );

    wire ext_rst_n = pins_sync[4];
    wire pd_pin = pins_sync[3];
    wire an_strap = pins_sync[2];
    wire cfg_b = pins_sync[1];
    wire cfg_a = pins_sync[0];

    // ************************************************************
    // reset sequencing
    // ************************************************************
    phase_t state_q;
    phase_t state_d;
    logic [23:0] rst_cnt_q;

    wire rst_end = (rst_cnt_q == RST_CYC - 24'h000001);
    wire running = (state_q == ST_RUN);
    wire sampling = (state_q == ST_SAMPLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (rst_end) begin
                    state_d = ST_SAMPLE; // RL14
                end
            end
            ST_SAMPLE: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        // pin reset restarts the whole sequence from any phase
        if (!ext_rst_n) begin
            state_d = ST_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_RESET;
            rst_cnt_q <= 24'h000000;
        end else begin
            state_q <= state_d;
            if (!ext_rst_n || state_q != ST_RESET) begin
                rst_cnt_q <= 24'h000000;
            end else if (!rst_end) begin
                rst_cnt_q <= rst_cnt_q + 24'h000001; // RL14
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reset_done_flag_o <= 1'b0;
        end else begin
            reset_done_flag_o <= (state_d == ST_RUN); // RL15
        end
    end

    // ************************************************************
    // registers and strap capture
    // ************************************************************
    logic [15:0] ctrl_q;
    logic [15:0] lcfg_q;
    logic [LED_NUM-1:0] strap_q;
    logic [1:0] adv_q;

    logic [7:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_full_q;

    wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
    wire [7:0] wr_addr = {aw_addr_q[7:2], 2'b00};
    wire wr_ctrl = wr_fire && running && (wr_addr == ADDR_CTRL);
    wire wr_lcfg = wr_fire && running && (wr_addr == ADDR_LCFG);
    wire wr_mapped = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_LCFG)
                     || (wr_addr == ADDR_STRAP);
    wire [15:0] ctrl_wval = {wstrb_q[1] ? wdata_q[15:8] : ctrl_q[15:8],
                             wstrb_q[0] ? wdata_q[7:0] : ctrl_q[7:0]};
    wire [15:0] lcfg_wval = {wstrb_q[1] ? wdata_q[15:8] : lcfg_q[15:8],
                             wstrb_q[0] ? wdata_q[7:0] : lcfg_q[7:0]};
    wire [15:0] strap_stat = 16'({strap_q, 3'b000});

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || state_q == ST_RESET) begin
            ctrl_q <= CTRL_RST;
            lcfg_q <= LCFG_RST;
            strap_q <= '0;
            adv_q <= 2'b00;
        end else if (sampling) begin
            strap_q <= strap_sync; // RL3
            adv_q <= {cfg_b, cfg_a}; // RL10
            ctrl_q[CTRL_AUTONEG_BIT] <= an_strap;
            if (!an_strap) begin
                lcfg_q[LCFG_MLT3_BYP_BIT] <= cfg_a; // RL11
                ctrl_q[CTRL_LOOPBACK_BIT] <= cfg_b; // RL12
            end
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wval;
            end
            if (wr_lcfg) begin
                lcfg_q <= lcfg_wval;
            end
        end
    end

    assign autoneg_en_o = ctrl_q[CTRL_AUTONEG_BIT];
    assign advertise_sel_o = adv_q;
    assign mlt3_bypass_o = lcfg_q[LCFG_MLT3_BYP_BIT];
    assign loopback_o = ctrl_q[CTRL_LOOPBACK_BIT];

    // ************************************************************
    // AXI4-Lite write and read channels
    // ************************************************************
    assign s_axi_awready_o = !aw_full_q && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_full_q && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    wire [7:0] rd_addr = {s_axi_araddr_i[7:2], 2'b00};
    wire rd_ctrl = (rd_addr == ADDR_CTRL);
    wire rd_lcfg = (rd_addr == ADDR_LCFG);
    wire rd_strap = (rd_addr == ADDR_STRAP);
    wire [15:0] rd_val = rd_ctrl ? ctrl_q : rd_lcfg ? lcfg_q : rd_strap ? strap_stat : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {16'h0000, rd_val};
            s_axi_rresp_o <= (rd_ctrl || rd_lcfg || rd_strap) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ************************************************************
    // LED drive
    // ************************************************************
    logic act_blink;
    logic col_blink;
    logic [LED_NUM-1:0] led_on;

    wire powered_down = pd_pin || ctrl_q[CTRL_PWRDN_BIT];
    wire col_half = collision_i && !full_duplex_i;

    led_blink #(.HALF_CYCLES(ACT_HALF)) u_act_blink (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(activity_i), // RL5
        .blink_o(act_blink)
    );

    led_blink #(.HALF_CYCLES(COL_HALF)) u_col_blink (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(col_half), // RL8
        .blink_o(col_blink)
    );

    assign led_on[LED_TEN] = speed_ten_det_i; // RL4
    assign led_on[LED_ACT] = act_blink; // RL5
    assign led_on[LED_LINK] = link_good_i; // RL6
    assign led_on[LED_COLL] = full_duplex_i || col_blink; // RL7 RL8
    assign led_on[LED_HUNDRED] = speed_hundred_det_i; // RL9

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            led_o <= '0;
            led_oe_o <= '0;
            power_down_o <= 1'b0;
        end else begin
            // strap high inverts the driver, strap low drives straight
            led_o <= led_on ^ strap_q; // RL1 RL2
            // pins stay inputs until straps are taken
            led_oe_o <= (running && !powered_down) ? '1 : '0; // RL16
            power_down_o <= powered_down;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence sample_then_done_s;
        sampling && ext_rst_n ##1 running && reset_done_flag_o;
    endsequence

    strap_low_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL1
        running && !strap_q[LED_HUNDRED] && speed_hundred_det_i ##1 running
        |-> led_o[LED_HUNDRED])
        else $error("low strap LED not active high");
    strap_high_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL2
        running && strap_q[LED_TEN] && speed_ten_det_i ##1 running |-> !led_o[LED_TEN])
        else $error("high strap LED not active low");
    strap_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL3
        sampling |=> strap_stat[7:STRAP_LSB] == $past(strap_sync))
        else $error("strap status not latched");
    link_led_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL6
        running && link_good_i ##1 running |-> led_o[LED_LINK] != strap_q[LED_LINK])
        else $error("link LED not on");
    full_dup_led_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL7
        running && full_duplex_i ##1 running |-> led_o[LED_COLL] != strap_q[LED_COLL])
        else $error("duplex LED not on");
    quiet_coll_led_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL8
        running && !full_duplex_i && !collision_i ##1 running && !collision_i && !full_duplex_i
        |=> led_o[LED_COLL] == strap_q[LED_COLL])
        else $error("duplex LED on without cause");
    idle_act_led_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL5
        running && !activity_i ##1 running && !activity_i
        |=> led_o[LED_ACT] == strap_q[LED_ACT])
        else $error("activity LED on while idle");
    strap_apply_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL11 RL12
        sampling && !an_strap && ext_rst_n
        |=> mlt3_bypass_o == $past(cfg_a) && loopback_o == $past(cfg_b))
        else $error("config straps not applied");
    advert_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL10
        sampling && ext_rst_n |=> advertise_sel_o == $past({cfg_b, cfg_a}))
        else $error("advertisement straps not latched");
    reset_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL14
        state_q == ST_RESET && !rst_end |=> !reset_done_flag_o && !running)
        else $error("reset ended early");
    done_after_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL15
        sampling && ext_rst_n |-> sample_then_done_s)
        else $error("reset done flag late");
    pd_float_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL16
        powered_down |=> led_oe_o == '0)
        else $error("LED driven in power-down");
endmodule : phy_pin_ctrl

/* board_model.sv */
// Purpose: board around the pins: strap resistors, LED pins and reset source
// Assumes: a released LED pin settles to its strap resistor level
// Notes: hold count stands in for the long reset low time
`timescale 1ns/10ps
module board_model #(
    parameter int HOLD_CYC = 24
) (
    // clock and requests
    input wire logic clk_i,
    input wire logic reset_req_i,
    input wire logic [4:0] strap_i,
    // pins
    input wire logic [4:0] led_drive_i,
    input wire logic [4:0] led_oe_i,
    output logic [4:0] led_pin_o,
    output logic ext_reset_n_o
);
    int cnt_q = 0;
    // undriven pin shows its pull resistor, never the last driven level
    assign led_pin_o = (led_oe_i & led_drive_i) | (~led_oe_i & strap_i);
    always @(posedge clk_i) begin
        if (reset_req_i) begin
            cnt_q <= HOLD_CYC;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign ext_reset_n_o = (cnt_q == 0);
endmodule : board_model

/* phy_pin_ctrl_bench.sv */
// Purpose: self-checking bench of the strap, LED and reset block
// Assumes: short reset and blink counts set by parameter
// Notes: pins and bus sampled on the falling edge, driven after the rising one
`timescale 1ns/10ps
module phy_pin_ctrl_bench;
    import phy_pin_pkg::*;
    localparam logic [23:0] RST_N = 24'h000014;
    localparam logic [23:0] ACT_N = 24'h000008;
    localparam logic [23:0] COL_N = 24'h000004;
    localparam int HOLD = 24;
    logic clk_i = 1'b0, reset_n_i = 1'b0, power_down_pin_i = 1'b0, req = 1'b0;
    logic autoneg_strap_i = 1'b0, config_strap_a_i = 1'b0, config_strap_b_i = 1'b0;
    logic collision_i = 1'b0, ext_n, reset_done_flag_o, autoneg_en_o;
    logic mlt3_bypass_o, loopback_o, power_down_o;
    logic [1:0] advertise_sel_o;
    logic [4:0] st = 5'h00, strap = 5'h00, led_pin, led_o, led_oe_o;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int fail_count = 0, num_checks = 0;

    phy_pin_ctrl #(.RST_CYC(RST_N), .ACT_HALF(ACT_N), .COL_HALF(COL_N)) DUT (
        .clk_i, .reset_n_i, .ext_reset_n_i(ext_n), .power_down_pin_i, .autoneg_strap_i,
        .config_strap_a_i, .config_strap_b_i, .reset_done_flag_o, .led_i(led_pin), .led_o,
        .led_oe_o, .speed_ten_det_i(st[4]), .speed_hundred_det_i(st[0]), .link_good_i(st[2]),
        .activity_i(st[3]), .full_duplex_i(st[1]), .collision_i, .autoneg_en_o,
        .advertise_sel_o, .mlt3_bypass_o, .loopback_o, .power_down_o,
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    board_model #(.HOLD_CYC(HOLD)) board (.clk_i, .reset_req_i(req), .strap_i(strap),
        .led_drive_i(led_o), .led_oe_i(led_oe_o), .led_pin_o(led_pin), .ext_reset_n_o(ext_n));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ************************************************************
    // compare and bus tasks
    // ************************************************************
    task automatic test_done();
        $display("checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic timeout();
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        test_done();
    endtask : timeout

    task automatic chk_word(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: bus result %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_pins(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: pins %h, expected %h", $time, got, exp);
        end
    endtask : chk_pins

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, pb, ta, tw, tb;
        logic [1:0] r;
        int n;
        {pa, pw, pb, r, n} = {5'b11111, 32'h0};
        @(posedge clk_i);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        while ((pa | pw | pb) && n < 100) begin
            @(negedge clk_i);
            {ta, tw, tb} = {pa & awready, pw & wready, pb & bvalid};
            if (tb) r = bresp;
            @(posedge clk_i);
            {pa, pw, pb} = {pa & ~ta, pw & ~tw, pb & ~tb};
            {awvalid, wvalid, bready} <= {pa, pw, pb};
            n++;
        end
        if (pa | pw | pb) timeout();
        chk_word({r, 32'h0}, {er, 32'h0});
    endtask : wr_chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic pa, pr, ta, tr;
        logic [33:0] got;
        int n;
        {pa, pr, got, n} = {2'b11, 34'h0, 32'h0};
        @(posedge clk_i);
        {araddr, arvalid, rready} <= {a, 2'b11};
        while ((pa | pr) && n < 100) begin
            @(negedge clk_i);
            {ta, tr} = {pa & arready, pr & rvalid};
            if (tr) got = {rresp, rdata};
            @(posedge clk_i);
            {pa, pr} = {pa & ~ta, pr & ~tr};
            {arvalid, rready} <= {pa, pr};
            n++;
        end
        if (pa | pr) timeout();
        chk_word(got, {er, ed});
    endtask : rd_chk

    // pin reset goes through the board model, power-on reset through reset_n_i
    task automatic boot(input logic pin, input logic an, input logic a, input logic b,
                        input logic [4:0] s);
        int n;
        {autoneg_strap_i, config_strap_a_i, config_strap_b_i} <= {an, a, b};
        {strap, st, collision_i} <= {s, 6'h00};
        {req, reset_n_i} <= {pin, pin};
        repeat (2) @(posedge clk_i);
        {req, reset_n_i} <= 2'b01;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            if (n == 6) chk_pins(16'(reset_done_flag_o), 16'h0);
        end while ((n < 6 || reset_done_flag_o !== 1'b1) && n < 300);
        @(posedge clk_i);
        if (n >= 300) timeout();
        chk_pins(16'(n > (pin ? HOLD - 2 : 0) + RST_N && n <= (pin ? HOLD : 0) + RST_N + 8),
                 16'h1);
    endtask : boot

    task automatic blink(input int k, input int half);
        int n;
        n = 0;
        @(negedge clk_i);
        while (led_o[k] === strap[k] && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        for (int j = 0; j < 4 * half; j++) begin
            chk_pins(16'(led_o[k]), 16'(strap[k] ^ ((j / half) % 2 == 0)));
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask : blink

    initial begin
        logic an, a, b;
        logic [4:0] s;
        logic [31:0] ctl, d;
        void'($urandom(34));
        for (int i = 0; i < 4; i++) begin
            {an, a, b, s} = {1'(i), 1'($urandom), 1'($urandom), 5'($urandom)};
            boot(i != 0, an, a, b, s);
            // registers only touched once reset done is seen
            ctl = {17'h0, !an & b, 1'b0, an, 12'h0};
            wr_chk(ADDR_STRAP, 32'hFF, RESP_OKAY);
            rd_chk(ADDR_STRAP, {24'h0, s, 3'h0}, RESP_OKAY);
            rd_chk(ADDR_CTRL, ctl, RESP_OKAY);
            rd_chk(ADDR_LCFG, {30'h0, !an & a, 1'b0}, RESP_OKAY);
            @(negedge clk_i);
            chk_pins(16'({autoneg_en_o, advertise_sel_o, loopback_o, mlt3_bypass_o}),
                     16'({an, b, a, !an & b, !an & a}));
            chk_pins({led_oe_o, led_o}, {5'h1F, s});
            @(posedge clk_i);
            for (int k = 0; k < 5; k++) begin
                if (k != LED_ACT) begin
                    st <= 5'(1 << k);
                    repeat (3) @(negedge clk_i);
                    chk_pins(16'(led_o), 16'(s ^ 5'(1 << k)));
                    @(posedge clk_i);
                end
            end
            st <= 5'h08;
            blink(LED_ACT, ACT_N);
            {st, collision_i} <= {5'h00, 1'b1};
            blink(LED_COLL, COL_N);
            st <= 5'h02;
            repeat (3) @(negedge clk_i);
            chk_pins(16'(led_o), 16'(s ^ 5'h02));
            @(posedge clk_i);
            {st, collision_i} <= {5'h00, 1'b0};
            wr_chk(ADDR_CTRL, ctl | 32'h800, RESP_OKAY);
            repeat (3) @(negedge clk_i);
            chk_pins({power_down_o, led_oe_o, led_pin}, {6'h20, s});
            @(posedge clk_i);
            wr_chk(ADDR_CTRL, ctl, RESP_OKAY);
            power_down_pin_i <= 1'b1;
            repeat (5) @(negedge clk_i);
            chk_pins({power_down_o, led_oe_o, led_o}, {6'h20, s});
            @(posedge clk_i);
            power_down_pin_i <= 1'b0;
            repeat (5) @(negedge clk_i);
            chk_pins({power_down_o, led_oe_o, led_o}, {6'h1F, s});
            @(posedge clk_i);
            d = 32'($urandom) & 32'h0000FFFF;
            wr_chk(ADDR_LCFG, d, RESP_OKAY);
            rd_chk(ADDR_LCFG, d, RESP_OKAY);
            rd_chk(8'h10, 32'h0, RESP_SLVERR);
            wr_chk(8'h10, d, RESP_SLVERR);
        end
        test_done();
    end
endmodule : phy_pin_ctrl_bench
